// >>> test/cbx_branch_exec_bench.sv
// self-checking bench for the branch execution block
module cbx_branch_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cbx_pkg::*;
  // ----------------------------------------
  // signals and instance
  // ----------------------------------------
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         start = 1'b0;
  cbx_instr_s   instr = '0;
  cbx_operand_s operand = '0;
  logic         busy, done, recognized, taken, pcWrite, bitRead;
  logic [15:0]  pcOut;
  logic [7:0]   bitAddr;
  logic [1:0]   instrBytes;
  int           errorCnt = 0;
  int           comparisons = 0;
  int           cycles = 0;
  always #4 clk = ~clk;
  cbx_branch_exec cbx_branch_exec_i (
    .clk(clk), .sys_rst(sys_rst), .start(start), .instr(instr), .operand(operand),
    .busy(busy), .done(done), .recognized(recognized), .taken(taken), .pcWrite(pcWrite),
    .pcOut(pcOut), .bitAddr(bitAddr), .bitRead(bitRead), .instrBytes(instrBytes)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      errorCnt++;
    end
  endtask : check
  task automatic finish_test();
    if (errorCnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // poke holds start high for the first busy cycle, with another opcode, which must be ignored
  task automatic run_op(input logic [7:0] op, b2, b3, input logic [15:0] pc, input logic [7:0] acc,
                        input logic [15:0] dp, input logic c, tb, poke, input logic [15:0] expPc,
                        input logic expTaken, input logic [1:0] expBytes);
    logic rec;
    rec = (op == 8'h30) || (op == 8'h40) || (op == 8'h50) || (op == 8'h73);
    @(posedge clk);
    start   <= 1'b1;
    instr   <= '{op, b2, b3, pc};
    operand <= '{acc, dp, c, tb};
    @(posedge clk);
    start <= poke;
    if (poke) begin
      instr.opcode <= 8'h40;
    end
    #1;
    check("busy", 16'(busy), 16'h0001);
    check("bitRead", 16'(bitRead), 16'(op == 8'h30));
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    #1;
    check("done", 16'(done), 16'h0001);
    check("pcWrite", 16'(pcWrite), 16'(rec));
    check("recognized", 16'(recognized), 16'(rec));
    if (rec) begin
      check("pcOut", pcOut, expPc);
      check("taken", 16'(taken), 16'(expTaken));
      check("instrBytes", 16'(instrBytes), 16'(expBytes));
    end
    if (op == 8'h30) begin
      check("bitAddr", 16'(bitAddr), 16'(b2));
    end
    @(posedge clk);
    #1;
    check("doneEnd", 16'({busy, done}), 16'h0000);
  endtask : run_op
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // flags, accumulator, pointer and bits have no write path at the ports
  task automatic carry_set_case();
    run_op(8'h40, 8'hfe, 8'h00, 16'h1000, 8'h00, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h1000, 1'b1, 2'h2);
    run_op(8'h40, 8'h7f, 8'h00, 16'h1000, 8'h00, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h1002, 1'b0, 2'h2);
  endtask : carry_set_case
  task automatic carry_clear_case();
    run_op(8'h50, 8'h7f, 8'h00, 16'hfff0, 8'h00, 16'h0000, 1'b0, 1'b1, 1'b0, 16'h0071, 1'b1, 2'h2);
    run_op(8'h50, 8'h80, 8'h00, 16'hfff0, 8'h00, 16'h0000, 1'b1, 1'b0, 1'b0, 16'hfff2, 1'b0, 2'h2);
  endtask : carry_clear_case
  // displacement in byte three; a wrong byte would give 0x0068
  task automatic bit_clear_case();
    run_op(8'h30, 8'h55, 8'h80, 16'h0010, 8'h00, 16'h0000, 1'b1, 1'b0, 1'b0, 16'hff93, 1'b1, 2'h3);
    run_op(8'h30, 8'h55, 8'h80, 16'h0010, 8'h00, 16'h0000, 1'b0, 1'b1, 1'b0, 16'h0013, 1'b0, 2'h3);
  endtask : bit_clear_case
  // carry out of the low byte must reach the high byte
  task automatic indirect_case();
    run_op(8'h73, 8'h00, 8'h00, 16'h4000, 8'hff, 16'hff01, 1'b0, 1'b0, 1'b1, 16'h0000, 1'b1, 2'h1);
    run_op(8'h73, 8'h00, 8'h00, 16'h4000, 8'h04, 16'h12fe, 1'b1, 1'b1, 1'b0, 16'h1302, 1'b1, 2'h1);
  endtask : indirect_case
  task automatic unknown_case();
    run_op(8'h70, 8'h10, 8'h00, 16'h2000, 8'h00, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b0, 2'h0);
  endtask : unknown_case
  // reset in mid-run must drop the pending result
  task automatic reset_case();
    @(posedge clk);
    start <= 1'b1;
    instr <= '{8'h40, 8'h10, 8'h00, 16'h3000};
    @(posedge clk);
    start   <= 1'b0;
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("afterReset", {busy, done, pcWrite, pcOut[12:0]}, 16'h0000);
  endtask : reset_case
  // ----------------------------------------
  // main sequence and timeout
  // ----------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      errorCnt++;
      finish_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    carry_set_case();
    carry_clear_case();
    bit_clear_case();
    indirect_case();
    unknown_case();
    reset_case();
    finish_test();
  end
endmodule : cbx_branch_exec_bench

// >>> verilog/cbx_branch_exec.sv
// execution of the carry, bit-clear and indirect branches
`include "cbx_defines.svh"
module cbx_branch_exec (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 start,
  input  wire cbx_pkg::cbx_instr_s  instr,
  input  wire cbx_pkg::cbx_operand_s operand,
  output logic                      busy,
  output logic                      done,
  output logic                      recognized,
  output logic                      taken,
  output logic                      pcWrite,
  output logic      [15:0]          pcOut,
  output logic      [7:0]           bitAddr,
  output logic                      bitRead,
  output logic      [1:0]           instrBytes
);
  import cbx_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  cbx_state_e  state;
  cbx_state_e  next_state;
  cbx_instr_s  held;
  cbx_operand_s heldOp;
  logic        isCarrySet;
  logic        isCarryClear;
  logic        isBitClear;
  logic        isIndirect;
  logic        known;
  logic [15:0] length;
  logic [7:0]  displacement;
  logic [15:0] nextPc;
  logic [15:0] branchPc;
  logic        cond;
  logic [1:0]  cycleCount;

  assign isCarrySet   = held.opcode == `CBX_OP_CARRY_SET;
  assign isCarryClear = held.opcode == `CBX_OP_CARRY_CLEAR;
  assign isBitClear   = held.opcode == `CBX_OP_BIT_CLEAR;
  assign isIndirect   = held.opcode == `CBX_OP_INDIRECT;
  assign known        = isCarrySet | isCarryClear | isBitClear | isIndirect;

  always_comb begin
    length       = `CBX_LEN_TWO;
    displacement = held.byte2;
    if (isBitClear) begin
      length       = `CBX_LEN_THREE;
      displacement = held.byte3;
    end else if (isIndirect) begin
      length = `CBX_LEN_ONE;
    end
  end

  cbx_target_calc cbx_target_calc_i (
    .base        (held.pc),
    .length      (length),
    .displacement(displacement),
    .nextPc      (nextPc),
    .branchPc    (branchPc)
  );

  always_comb begin
    cond = 1'b0;
    if (isCarrySet) begin
      cond = heldOp.carry;
    end else if (isCarryClear) begin
      cond = ~heldOp.carry;
    end else if (isBitClear) begin
      cond = ~heldOp.testBit;
    end else if (isIndirect) begin
      cond = 1'b1;
    end
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      CBX_IDLE: begin
        if (start) begin
          next_state = CBX_EXEC;
        end
      end
      CBX_EXEC: begin
        if (cycleCount == `CBX_CYCLES - 2'h1) begin
          next_state = CBX_DONE;
        end
      end
      CBX_DONE: next_state = CBX_IDLE;
      default:  next_state = CBX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= CBX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cycleCount <= 2'h0;
    end else if (state == CBX_IDLE) begin
      cycleCount <= 2'h0;
    end else if (state == CBX_EXEC) begin
      cycleCount <= cycleCount + 2'h1;
    end
  end

  // operands are latched so the caller may change them after start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      held   <= '0;
      heldOp <= '0;
    end else if (state == CBX_IDLE && start) begin
      held   <= instr;
      heldOp <= operand;
    end
  end

  // ----------------------------------------
  // results
  // ----------------------------------------
  // no flag, accumulator, pointer or bit output exists: nothing can be written back
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pcOut      <= `CBX_PC_RESET;
      taken      <= 1'b0;
      recognized <= 1'b0;
      instrBytes <= 2'h0;
    end else if (state == CBX_EXEC && next_state == CBX_DONE) begin
      recognized <= known;
      taken      <= known & cond;
      instrBytes <= length[1:0];
      if (isIndirect) begin
        pcOut <= {8'h00, heldOp.acc} + heldOp.dataPointer16;
      end else if (known && cond) begin
        pcOut <= branchPc;
      end else begin
        pcOut <= nextPc;
      end
    end
  end

  assign busy    = state != CBX_IDLE;
  assign done    = state == CBX_DONE;
  assign pcWrite = done & recognized;
  assign bitAddr = held.byte2;
  assign bitRead = (state == CBX_EXEC) & isBitClear;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  carry_set_taken_a: assert property (@(posedge clk) disable iff (sys_rst)
    done && held.opcode == `CBX_OP_CARRY_SET && heldOp.carry
    |-> pcOut == held.pc + 16'h0002 + {{8{held.byte2[7]}}, held.byte2})
    else $error("carry-set target wrong");
  carry_clear_taken_a: assert property (@(posedge clk) disable iff (sys_rst)
    done && held.opcode == `CBX_OP_CARRY_CLEAR
    |-> pcOut == (heldOp.carry ? held.pc + 16'h0002
                  : held.pc + 16'h0002 + {{8{held.byte2[7]}}, held.byte2}))
    else $error("carry-clear target wrong");
  bit_clear_target_a: assert property (@(posedge clk) disable iff (sys_rst)
    done && held.opcode == `CBX_OP_BIT_CLEAR
    |-> pcOut == (heldOp.testBit ? held.pc + 16'h0003
                  : held.pc + 16'h0003 + {{8{held.byte3[7]}}, held.byte3}))
    else $error("bit-clear target wrong");
  indirect_sum_a: assert property (@(posedge clk) disable iff (sys_rst)
    done && held.opcode == `CBX_OP_INDIRECT
    |-> pcOut == heldOp.dataPointer16 + {8'h00, heldOp.acc})
    else $error("indirect target wrong");
  exec_two_cycles_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == CBX_IDLE && start |=> busy && !done ##1 !done ##1 done)
    else $error("execution not two cycles");
  carry_set_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    done && held.opcode == `CBX_OP_CARRY_SET && !heldOp.carry |-> pcOut == held.pc + 16'h0002)
    else $error("carry-set fall-through wrong");
  length_code_a: assert property (@(posedge clk) disable iff (sys_rst)
    pcWrite |-> instrBytes == (held.opcode == `CBX_OP_BIT_CLEAR ? 2'h3
                 : held.opcode == `CBX_OP_INDIRECT ? 2'h1 : 2'h2))
    else $error("instruction length wrong");
  bit_read_only_a: assert property (@(posedge clk) disable iff (sys_rst)
    bitRead |-> held.opcode == `CBX_OP_BIT_CLEAR && bitAddr == held.byte2)
    else $error("bit access outside bit-clear branch");
  unknown_no_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    done && !known |-> !pcWrite && !taken)
    else $error("unknown opcode wrote pc");
  carry_set_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    pcWrite && held.opcode == `CBX_OP_CARRY_SET |-> taken == heldOp.carry)
    else $error("carry-set taken flag wrong");
  carry_clear_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    pcWrite && held.opcode == `CBX_OP_CARRY_CLEAR |-> taken == !heldOp.carry)
    else $error("carry-clear taken flag wrong");
  bit_clear_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    pcWrite && held.opcode == `CBX_OP_BIT_CLEAR |-> taken == !heldOp.testBit)
    else $error("bit-clear taken flag wrong");
  indirect_taken_a: assert property (@(posedge clk) disable iff (sys_rst)
    pcWrite && held.opcode == `CBX_OP_INDIRECT |-> taken && instrBytes == 2'h1)
    else $error("indirect jump not taken or wrong length");
  done_one_cycle_a: assert property (@(posedge clk) disable iff (sys_rst)
    done |=> !done && !busy)
    else $error("done longer than one cycle");
  // a start while busy must not reload the latched instruction or its operands
  operands_kept_a: assert property (@(posedge clk) disable iff (sys_rst)
    busy |=> $stable(held) && $stable(heldOp))
    else $error("operands changed while busy");
  bit_read_window_a: assert property (@(posedge clk) disable iff (sys_rst)
    bitRead |-> busy && !done)
    else $error("bit read outside execution");
  // results stay up until the next instruction finishes; the core may read them late
  result_stands_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(state == CBX_EXEC && next_state == CBX_DONE) |=> $stable(pcOut) && $stable(taken) && $stable(recognized))
    else $error("result changed between instructions");

  carry_taken_c:    cover property (@(posedge clk) pcWrite && taken && isCarrySet);
  carry_clear_c:    cover property (@(posedge clk) pcWrite && !taken && isCarryClear);
  bit_clear_back_c: cover property (@(posedge clk) pcWrite && taken && isBitClear && held.byte3[7]);
  indirect_wrap_c:  cover property (@(posedge clk) pcWrite && isIndirect && pcOut < heldOp.dataPointer16);
  unknown_op_c:     cover property (@(posedge clk) done && !recognized);
endmodule : cbx_branch_exec

// >>> verilog/cbx_defines.svh
// constants for the conditional branch execution block
`ifndef CBX_DEFINES_SVH
`define CBX_DEFINES_SVH
`define CBX_OP_CARRY_SET   8'h40
`define CBX_OP_CARRY_CLEAR 8'h50
`define CBX_OP_BIT_CLEAR   8'h30
`define CBX_OP_INDIRECT    8'h73
`define CBX_LEN_ONE        16'h0001
`define CBX_LEN_TWO        16'h0002
`define CBX_LEN_THREE      16'h0003
`define CBX_CYCLES         2'h2
`define CBX_SIGN_BIT       7
`define CBX_PC_RESET       16'h0000
`endif

// >>> verilog/cbx_pkg.sv
// types shared by the conditional branch execution block
package cbx_pkg;
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  byte2;
    logic [7:0]  byte3;
    logic [15:0] pc;
  } cbx_instr_s;
  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] dataPointer16;
    logic        carry;
    logic        testBit;
  } cbx_operand_s;
  typedef enum logic [2:0] {
    CBX_IDLE = 3'b001,
    CBX_EXEC = 3'b010,
    CBX_DONE = 3'b100
  } cbx_state_e;
endpackage : cbx_pkg

// >>> verilog/cbx_target_calc.sv
// target address arithmetic
`include "cbx_defines.svh"
module cbx_target_calc (
  input  wire logic [15:0] base,
  input  wire logic [15:0] length,
  input  wire logic [7:0]  displacement,
  output logic      [15:0] nextPc,
  output logic      [15:0] branchPc
);
  logic [15:0] signExt;
  // sign extension keeps backward branches correct; sum wraps by width
  assign signExt  = {{8{displacement[`CBX_SIGN_BIT]}}, displacement};
  assign nextPc   = base + length;
  assign branchPc = nextPc + signExt;
endmodule : cbx_target_calc
